// >>> design/dbc_pkg.sv
// Purpose: Shared constants for the background debug command port
// Assumes: Both ends and the bench import this package
// Notes:   Frame is one low pulse of frame_n; bits MSB first
// Operation
// - Background code enters debug mode when unlocked
// - Read command takes address, returns sixteen data
// - Write command takes address then sixteen data
// - Plain codes access normal map, debug out
// - Byte data: odd low half, even high
// - Host sends word commands only at aligned addresses
// - Debug space mapped in only during access
// - Bus held until the access finishes
// - Processor clocks frozen during multi-cycle access
// - Firmware commands served only in background mode
// - Debug ROM at FF20 to FFFF when active
// - Seven debug registers at FF00 to FF06
// - Host waits 32 debug clocks after firmware write
// - Host waits 64 debug clocks after step/resume
// - Lockout blocks debug mode and hides ROM
// - Lockout when bit zero; loaded from shadow
// - Lockout bit changes only in special mode
// - Software unprotects, unhides, writes 7F to 0FC0
package dbc_pkg;
  // -----------------------------------------------------------------
  // Command codes and frame layout
  // -----------------------------------------------------------------
  localparam logic [7:0]  CMD_BACKGROUND = 8'h90;
  localparam logic [7:0]  HW_MASK        = 8'hd3;
  localparam logic [7:0]  HW_MATCH       = 8'hc0;
  localparam int          HW_RD_BIT      = 5;
  localparam int          HW_WORD_BIT    = 3;
  localparam int          HW_BD_BIT      = 2;
  localparam int          CODE_BITS      = 8;
  localparam int          ADDR_BITS      = 16;
  localparam int          DATA_BITS      = 16;
  localparam int          HW_RD_END      = CODE_BITS + ADDR_BITS;
  localparam int          HW_WR_END      = HW_RD_END + DATA_BITS;
  localparam int          FW_WR_GAP      = 32;
  localparam int          STEP_GAP       = 64;
  // -----------------------------------------------------------------
  // Debug resource map
  // -----------------------------------------------------------------
  localparam logic [15:0] ROM_LO  = 16'hff20;
  localparam logic [15:0] ROM_HI  = 16'hffff;
  localparam logic [15:0] DREG_LO = 16'hff00;
  localparam logic [15:0] DREG_HI = 16'hff06;
  // Pin sync reset: {special_n, frame_n, data, clock}
  localparam logic [3:0]  SYNC_RST = 4'hc;
  // -----------------------------------------------------------------
  // Host register map (byte offsets) and fields
  // -----------------------------------------------------------------
  localparam logic [4:0]  REG_CTRL  = 5'h00;
  localparam logic [4:0]  REG_ADDR  = 5'h04;
  localparam logic [4:0]  REG_WDATA = 5'h08;
  localparam logic [4:0]  REG_RDATA = 5'h0c;
  localparam logic [4:0]  REG_STAT  = 5'h10;
  localparam int          CTRL_FMT_LSB = 8;
  localparam int          CTRL_GAP_LSB = 10;
  localparam logic [1:0]  FMT_NONE  = 2'h0;
  localparam logic [1:0]  FMT_RD    = 2'h1;
  localparam logic [1:0]  FMT_WR    = 2'h2;
  localparam logic [1:0]  GAP_NONE  = 2'h0;
  localparam logic [1:0]  GAP_FW_WR = 2'h1;
  localparam logic [1:0]  GAP_STEP  = 2'h2;
  localparam int          STAT_BUSY  = 0;
  localparam int          STAT_ALIGN = 1;

  function automatic logic dbc_is_hw(input logic [7:0] code);
    return (code & HW_MASK) == HW_MATCH;
  endfunction : dbc_is_hw
endpackage : dbc_pkg

// >>> design/dbc_link_if.sv
// Purpose: Serial debug link between host end and device end
// Assumes: Host drives clock, data out and frame select
// Notes:   All wires one-way; no tristate
`timescale 1ns/10ps
interface dbc_link_if;
  logic sclk;
  logic h2d;
  logic d2h;
  logic frame_n;
  modport host (output sclk, output h2d, output frame_n, input d2h);
  modport dev  (input sclk, input h2d, input frame_n, output d2h);
endinterface : dbc_link_if

// >>> design/dbc_device.sv
// Purpose: Device end: command serial_shift_register, bus stealer, lockout, map
// Assumes: Link pins asynchronous; memory answers with mem_ready_i
// Notes:   Map selects lag cpu_addr_i by one cycle
//
// The Avalon-MM register port and the address map were decided locally.
`timescale 1ns/10ps
module dbc_device
  import dbc_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        srst_i,
  dbc_link_if.dev          link,
  input  wire logic        special_mode_pin_n_i,
  input  wire logic        shadow_bit_i,
  input  wire logic        ld_wr_i,
  input  wire logic        ld_wdata_i,
  input  wire logic        shadow_prog_req_i,
  output logic             shadow_prog_o,
  output logic             lockout_disable_bit_o,
  output logic             background_debug_mode_o,
  input  wire logic [15:0] cpu_addr_i,
  output logic             rom_sel_o,
  output logic             dreg_sel_o,
  output logic             mem_req_o,
  output logic             mem_we_o,
  output logic             mem_word_o,
  output logic             mem_bdmap_o,
  output logic [15:0]      mem_addr_o,
  output logic [15:0]      mem_wdata_o,
  input  wire logic [15:0] mem_rdata_i,
  input  wire logic        mem_ready_i,
  output logic             cpu_freeze_o,
  output logic             fw_cmd_valid_o,
  output logic [7:0]       fw_code_o,
  output logic             fw_word_valid_o,
  output logic [15:0]      fw_word_o,
  input  wire logic        fw_tx_load_i,
  input  wire logic [15:0] fw_tx_data_i,
  input  wire logic        fw_exit_i
);
  // -----------------------------------------------------------------
  // Pin synchronisers: change accepted once stages two and three agree
  // -----------------------------------------------------------------
  logic [3:0]  s1_ff;
  logic [3:0]  s2_ff;
  logic [3:0]  s3_ff;
  logic [3:0]  pin_ff;
  logic        sclk_d_ff;
  wire  [3:0]  pin_raw = {special_mode_pin_n_i, link.frame_n, link.h2d, link.sclk};
  wire  [3:0]  agree   = ~(s2_ff ^ s3_ff);
  wire  [3:0]  nxt_pin = (agree & s2_ff) | (~agree & pin_ff);

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      s1_ff     <= SYNC_RST;
      s2_ff     <= SYNC_RST;
      s3_ff     <= SYNC_RST;
      pin_ff    <= SYNC_RST;
      sclk_d_ff <= 1'b0;
    end else begin
      s1_ff     <= pin_raw;
      s2_ff     <= s1_ff;
      s3_ff     <= s2_ff;
      pin_ff    <= nxt_pin;
      sclk_d_ff <= pin_ff[0];
    end
  end

  wire in_frame = ~pin_ff[2];
  wire special  = ~pin_ff[3];
  wire rise     = in_frame & pin_ff[0] & ~sclk_d_ff;
  wire fall     = in_frame & ~pin_ff[0] & sclk_d_ff;

  // -----------------------------------------------------------------
  // Command serial_shift_register
  // -----------------------------------------------------------------
  logic [5:0]  cnt_ff;
  logic [15:0] in_sr_ff;
  logic [7:0]  code_ff;
  logic [15:0] addr_ff;
  logic        fw_ok_ff;
  logic        active_ff;
  logic        ld_bit_ff;
  logic        loaded_ff;

  // Actions fire on the falling edge after a field, so a fast read
  // can never load the output serial_shift_register before the host's last fall
  wire at_code  = fall & (cnt_ff == 6'(CODE_BITS));
  wire at_addr  = fall & (cnt_ff == 6'(HW_RD_END));
  wire at_data  = fall & (cnt_ff == 6'(HW_WR_END));
  wire hw_cmd   = dbc_is_hw(code_ff);
  wire hw_rd    = code_ff[HW_RD_BIT];
  wire go_rd    = at_addr & hw_cmd & hw_rd;
  wire go_wr    = at_data & hw_cmd & ~hw_rd;
  wire code_bg  = in_sr_ff[7:0] == CMD_BACKGROUND;
  wire code_fw  = ~dbc_is_hw(in_sr_ff[7:0]) & ~code_bg;
  wire fw_word  = fall & fw_ok_ff & (cnt_ff[3:0] == 4'h8) & (cnt_ff != 6'h08);

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      cnt_ff   <= 6'h00;
      in_sr_ff <= 16'h0000;
      code_ff  <= 8'h00;
      addr_ff  <= 16'h0000;
      fw_ok_ff <= 1'b0;
    end else if (!in_frame) begin
      cnt_ff   <= 6'h00;
      fw_ok_ff <= 1'b0;
    end else begin
      if (rise) begin
        in_sr_ff <= {in_sr_ff[14:0], pin_ff[1]};
        cnt_ff   <= (cnt_ff == 6'h3f) ? cnt_ff : cnt_ff + 6'h01;
      end
      if (at_code) begin
        code_ff  <= in_sr_ff[7:0];
        fw_ok_ff <= code_fw & active_ff;
      end
      if (at_addr) begin
        addr_ff <= in_sr_ff;
      end
    end
  end

  // -----------------------------------------------------------------
  // Lockout and background mode
  // -----------------------------------------------------------------
  // A same-cycle lockout write must also drop debug mode
  wire nxt_active = (~ld_bit_ff | (loaded_ff & ld_wr_i & special & ~ld_wdata_i)) ? 1'b0 :
                    (at_code & code_bg) ? 1'b1 :
                    fw_exit_i ? 1'b0 : active_ff;

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ld_bit_ff     <= 1'b0;
      loaded_ff     <= 1'b0;
      active_ff     <= 1'b0;
      shadow_prog_o <= 1'b0;
    end else begin
      // Strap caught on the first edge after release
      if (!loaded_ff) begin
        ld_bit_ff <= shadow_bit_i;
      end else if (ld_wr_i && special) begin
        ld_bit_ff <= ld_wdata_i;
      end
      loaded_ff     <= 1'b1;
      active_ff     <= nxt_active;
      shadow_prog_o <= shadow_prog_req_i & special;
    end
  end

  assign lockout_disable_bit_o   = ld_bit_ff;
  assign background_debug_mode_o = active_ff;

  // -----------------------------------------------------------------
  // Debug resource decode for processor accesses
  // -----------------------------------------------------------------
  wire map_on  = active_ff & ld_bit_ff;
  wire rom_hit = (cpu_addr_i >= ROM_LO) && (cpu_addr_i <= ROM_HI);
  wire reg_hit = (cpu_addr_i >= DREG_LO) && (cpu_addr_i <= DREG_HI);

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rom_sel_o  <= 1'b0;
      dreg_sel_o <= 1'b0;
    end else begin
      rom_sel_o  <= map_on & rom_hit;
      dreg_sel_o <= map_on & reg_hit;
    end
  end

  // -----------------------------------------------------------------
  // Stolen bus access
  // -----------------------------------------------------------------
  typedef enum {ACC_IDLE, ACC_BUS} dbc_acc_t;
  dbc_acc_t    acc_ff;
  logic [15:0] out_sr_ff;
  logic        out_arm_ff;
  wire  [15:0] acc_addr = go_rd ? in_sr_ff : addr_ff;
  wire         acc_go   = (go_rd | go_wr) & (acc_ff == ACC_IDLE);
  wire         acc_done = (acc_ff == ACC_BUS) & mem_ready_i;
  // Byte reads keep only the lane selected by the address
  wire  [15:0] rd_lane  = mem_word_o ? mem_rdata_i :
                          mem_addr_o[0] ? {8'h00, mem_rdata_i[7:0]} :
                          {mem_rdata_i[15:8], 8'h00};

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      acc_ff       <= ACC_IDLE;
      mem_req_o    <= 1'b0;
      mem_we_o     <= 1'b0;
      mem_word_o   <= 1'b0;
      mem_bdmap_o  <= 1'b0;
      mem_addr_o   <= 16'h0000;
      mem_wdata_o  <= 16'h0000;
      cpu_freeze_o <= 1'b0;
    end else begin
      case (acc_ff)
        ACC_IDLE: begin
          if (acc_go) begin
            acc_ff      <= ACC_BUS;
            mem_req_o   <= 1'b1;
            mem_we_o    <= ~hw_rd;
            mem_word_o  <= code_ff[HW_WORD_BIT];
            mem_bdmap_o <= code_ff[HW_BD_BIT] & ld_bit_ff;
            mem_addr_o  <= acc_addr;
            mem_wdata_o <= in_sr_ff;
          end
        end
        ACC_BUS: begin
          if (mem_ready_i) begin
            acc_ff      <= ACC_IDLE;
            mem_req_o   <= 1'b0;
            mem_bdmap_o <= 1'b0;
          end
        end
        default: acc_ff <= ACC_IDLE;
      endcase
      // Single-cycle accesses never freeze the processor
      cpu_freeze_o <= (acc_ff == ACC_BUS) & ~mem_ready_i;
    end
  end

  // -----------------------------------------------------------------
  // Output serial_shift_register and firmware hand-off
  // -----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      out_sr_ff       <= 16'h0000;
      out_arm_ff      <= 1'b0;
      fw_cmd_valid_o  <= 1'b0;
      fw_code_o       <= 8'h00;
      fw_word_valid_o <= 1'b0;
      fw_word_o       <= 16'h0000;
    end else begin
      if (acc_done && !mem_we_o) begin
        out_sr_ff  <= rd_lane;
        out_arm_ff <= 1'b1;
      end else if (fw_tx_load_i) begin
        out_sr_ff  <= fw_tx_data_i;
        out_arm_ff <= 1'b1;
      end else if (fall && out_arm_ff) begin
        out_sr_ff <= {out_sr_ff[14:0], 1'b0};
      end else if (!in_frame) begin
        out_arm_ff <= 1'b0;
      end
      fw_cmd_valid_o  <= at_code & code_fw & active_ff;
      fw_word_valid_o <= fw_word;
      if (at_code) begin
        fw_code_o <= in_sr_ff[7:0];
      end
      if (fw_word) begin
        fw_word_o <= in_sr_ff;
      end
    end
  end

  assign link.d2h = out_sr_ff[15];
endmodule : dbc_device

// >>> design/dbc_host.sv
// Purpose: Host end: Avalon-MM slave that issues serial debug frames
// Assumes: Device output latency below TURN_BITS debug clocks
// Notes:   Busy writes to the control register are ignored
`timescale 1ns/10ps
module dbc_host
  import dbc_pkg::*;
#(
  parameter int HALF_CYC  = 16,
  parameter int TURN_BITS = 16
) (
  input  wire logic        mclk_i,
  input  wire logic        srst_i,
  dbc_link_if.host         link,
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o
);
  // Returned data needs about ten cycles through both synchronisers
  if (HALF_CYC < 12 || HALF_CYC > 255 || TURN_BITS < 1 || TURN_BITS > 127) begin : g_bad
    $error("dbc_host: HALF_CYC or TURN_BITS out of range");
  end

  // -----------------------------------------------------------------
  // Register slave
  // -----------------------------------------------------------------
  typedef enum {H_IDLE, H_LEAD, H_TX, H_TURN, H_RX, H_TRAIL, H_POST} dbc_hst_t;
  dbc_hst_t    st_ff;
  logic [11:0] ctrl_ff;
  logic [15:0] addr_ff;
  logic [15:0] wdata_ff;
  logic [15:0] rdata_ff;
  logic        align_ff;
  wire         busy    = st_ff != H_IDLE;
  wire         acc     = (avs_read_i | avs_write_i) & avs_waitrequest_o;
  wire         wr_take = avs_write_i & ~avs_waitrequest_o;
  wire  [7:0]  wcode   = avs_writedata_i[7:0];
  wire         whw     = dbc_is_hw(wcode);
  wire         wr_ctrl = wr_take & (avs_address_i == REG_CTRL) & ~busy;
  wire         misal   = whw & wcode[HW_WORD_BIT] & addr_ff[0];
  wire         start   = wr_ctrl & ~misal;
  wire  [31:0] rd_mux  = (avs_address_i == REG_CTRL)  ? {20'h00000, ctrl_ff} :
                         (avs_address_i == REG_ADDR)  ? {16'h0000, addr_ff} :
                         (avs_address_i == REG_WDATA) ? {16'h0000, wdata_ff} :
                         (avs_address_i == REG_RDATA) ? {16'h0000, rdata_ff} :
                         (avs_address_i == REG_STAT)  ? {30'h0, align_ff, busy} :
                         32'h00000000;

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h00000000;
      ctrl_ff           <= 12'h000;
      addr_ff           <= 16'h0000;
      wdata_ff          <= 16'h0000;
      align_ff          <= 1'b0;
    end else begin
      avs_waitrequest_o <= ~acc;
      if (acc && avs_read_i) begin
        avs_readdata_o <= rd_mux;
      end
      if (wr_ctrl) begin
        ctrl_ff <= avs_writedata_i[11:0];
      end
      if (wr_take && avs_address_i == REG_ADDR) begin
        addr_ff <= avs_writedata_i[15:0];
      end
      if (wr_take && avs_address_i == REG_WDATA) begin
        wdata_ff <= avs_writedata_i[15:0];
      end
      // Set wins over a same-cycle clear
      if (wr_ctrl && misal) begin
        align_ff <= 1'b1;
      end else if (wr_take && avs_address_i == REG_STAT && avs_writedata_i[STAT_ALIGN]) begin
        align_ff <= 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------
  // Frame shape from the command code or the control format field
  // -----------------------------------------------------------------
  wire [1:0]  fmt    = whw ? (wcode[HW_RD_BIT] ? FMT_RD : FMT_WR)
                           : avs_writedata_i[CTRL_FMT_LSB +: 2];
  wire [7:0]  len_hw = wcode[HW_RD_BIT] ? 8'(HW_RD_END) : 8'(HW_WR_END);
  wire [7:0]  len_fw = (fmt == FMT_WR) ? 8'(CODE_BITS + DATA_BITS) : 8'(CODE_BITS);
  wire [39:0] frame  = whw ? {wcode, addr_ff, wdata_ff}
                           : {wcode, wdata_ff, 16'h0000};
  wire [1:0]  gsel   = ctrl_ff[CTRL_GAP_LSB +: 2];
  wire [7:0]  gap_h  = (gsel == GAP_FW_WR) ? 8'(2 * FW_WR_GAP) :
                       (gsel == GAP_STEP)  ? 8'(2 * STEP_GAP)  :
                       8'h00;

  // -----------------------------------------------------------------
  // Link engine
  // -----------------------------------------------------------------
  logic [2:0]  ms_ff;
  logic        miso_ff;
  logic [7:0]  div_ff;
  logic [7:0]  cnt_ff;
  logic [39:0] tx_ff;
  logic [15:0] rx_ff;
  logic        rx_on_ff;
  wire         tick  = div_ff == 8'(HALF_CYC - 1);
  wire         last  = cnt_ff == 8'h01;

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ms_ff   <= 3'h0;
      miso_ff <= 1'b0;
    end else begin
      ms_ff <= {ms_ff[1:0], link.d2h};
      if (ms_ff[1] == ms_ff[2]) begin
        miso_ff <= ms_ff[1];
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      st_ff        <= H_IDLE;
      div_ff       <= 8'h00;
      cnt_ff       <= 8'h00;
      tx_ff        <= 40'h0;
      rx_ff        <= 16'h0000;
      rx_on_ff     <= 1'b0;
      rdata_ff     <= 16'h0000;
      link.sclk    <= 1'b0;
      link.h2d     <= 1'b0;
      link.frame_n <= 1'b1;
    end else begin
      div_ff <= (tick || start) ? 8'h00 : div_ff + 8'h01;
      case (st_ff)
        H_IDLE: begin
          if (start) begin
            st_ff        <= H_LEAD;
            tx_ff        <= frame;
            cnt_ff       <= whw ? len_hw : len_fw;
            rx_on_ff     <= fmt == FMT_RD;
            link.frame_n <= 1'b0;
            link.h2d     <= frame[39];
          end
        end
        H_LEAD: if (tick) st_ff <= H_TX;
        H_TX: begin
          if (tick) begin
            link.sclk <= ~link.sclk;
            if (link.sclk) begin
              tx_ff    <= {tx_ff[38:0], 1'b0};
              link.h2d <= last ? 1'b0 : tx_ff[38];
              cnt_ff   <= last ? (rx_on_ff ? 8'(2 * TURN_BITS) : 8'h00) : cnt_ff - 8'h01;
              if (last) begin
                st_ff <= rx_on_ff ? H_TURN : H_TRAIL;
              end
            end
          end
        end
        H_TURN: begin
          if (tick) begin
            link.h2d <= 1'b0;
            cnt_ff   <= last ? 8'(DATA_BITS) : cnt_ff - 8'h01;
            if (last) begin
              st_ff <= H_RX;
            end
          end
        end
        H_RX: begin
          if (tick) begin
            link.sclk <= ~link.sclk;
            if (!link.sclk) begin
              rx_ff <= {rx_ff[14:0], miso_ff};
            end else begin
              cnt_ff <= cnt_ff - 8'h01;
              if (last) begin
                st_ff <= H_TRAIL;
              end
            end
          end
        end
        H_TRAIL: begin
          if (tick) begin
            link.frame_n <= 1'b1;
            if (rx_on_ff) begin
              rdata_ff <= rx_ff;
            end
            cnt_ff <= gap_h;
            st_ff  <= (gap_h == 8'h00) ? H_IDLE : H_POST;
          end
        end
        H_POST: begin
          if (tick) begin
            cnt_ff <= cnt_ff - 8'h01;
            if (last) begin
              st_ff <= H_IDLE;
            end
          end
        end
        default: st_ff <= H_IDLE;
      endcase
    end
  end
endmodule : dbc_host

// >>> tb/dbc_assertions.sv
// Purpose: Link framing and bus-steal checks
// Assumes: One clock, synchronous reset
// Notes:   Inputs are link wires and device user side
`timescale 1ns/10ps
module dbc_assertions (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic sclk,
  input wire logic h2d,
  input wire logic frame_n,
  input wire logic mem_req_o,
  input wire logic mem_ready_i,
  input wire logic mem_bdmap_o,
  input wire logic cpu_freeze_o,
  input wire logic background_debug_mode_o,
  input wire logic lockout_disable_bit_o,
  input wire logic rom_sel_o,
  input wire logic dreg_sel_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  // ----
  // Checks
  // ----
  property p_idle; frame_n |-> !sclk; endproperty
  a_idle: assert property (p_idle) else $error("clock outside frame");
  property p_bit; !frame_n && $past(!frame_n) && $changed(h2d) |-> $fell(sclk); endproperty
  a_bit: assert property (p_bit) else $error("data moved off clock fall");
  property p_half; $rose(sclk) |-> sclk [*8]; endproperty
  a_half: assert property (p_half) else $error("clock high too short");
  property p_bdmap; mem_bdmap_o |-> mem_req_o; endproperty
  a_bdmap: assert property (p_bdmap) else $error("debug map outside access");
  property p_hold; mem_req_o && !mem_ready_i |=> mem_req_o; endproperty
  a_hold: assert property (p_hold) else $error("bus dropped early");
  property p_one; $rose(mem_req_o) && mem_ready_i |=> !cpu_freeze_o; endproperty
  a_one: assert property (p_one) else $error("short access froze cpu");
  property p_frz; mem_req_o && $past(mem_req_o) |-> cpu_freeze_o; endproperty
  a_frz: assert property (p_frz) else $error("long access not frozen");
  property p_lock; background_debug_mode_o |-> lockout_disable_bit_o; endproperty
  a_lock: assert property (p_lock) else $error("debug mode while locked");
  property p_map; rom_sel_o || dreg_sel_o |-> $past(background_debug_mode_o); endproperty
  a_map: assert property (p_map) else $error("debug map while inactive");
  property p_ld0; $fell(srst_i) |-> !lockout_disable_bit_o; endproperty
  a_ld0: assert property (p_ld0) else $error("lockout bit early");
endmodule : dbc_assertions

// >>> tb/testbench.sv
// Purpose: Self-checking bench for host and device ends
// Assumes: Short link parameters; bench acts as memory
// Notes:   Rows hold code, address and write data
`timescale 1ns/10ps
module testbench
  import dbc_pkg::*;
;
  logic        mclk_i, srst_i, special_mode_pin_n_i, shadow_bit_i, ld_wr_i, ld_wdata_i;
  logic        shadow_prog_req_i, fw_tx_load_i, fw_exit_i, mem_ready_i, fast, rdy_ff;
  logic        avs_read_i, avs_write_i, avs_waitrequest_o, shadow_prog_o, rom_sel_o;
  logic        lockout_disable_bit_o, background_debug_mode_o, dreg_sel_o, mem_req_o;
  logic        mem_we_o, mem_word_o, mem_bdmap_o, cpu_freeze_o, fw_cmd_valid_o;
  logic        fw_word_valid_o;
  logic [2:0]  cap;
  logic [4:0]  avs_address_i;
  logic [7:0]  fw_code_o, cap_c, c;
  logic [15:0] cpu_addr_i, mem_rdata_i, fw_tx_data_i, mem_addr_o, mem_wdata_o, fw_word_o;
  logic [15:0] cap_a, cap_d, cap_w, a, d, e;
  logic [31:0] avs_writedata_i, avs_readdata_o, rdat;
  int          n_mismatch, num_checks, n_acc;
  localparam logic [39:0] ROWS [8] = '{40'he0_1235_0000, 40'he8_2468_0000, 40'he4_ff01_0000,
    40'hec_ff22_0000, 40'hc0_1001_00a5, 40'hc8_1002_beef, 40'hc4_ff04_5a00, 40'hcc_ff20_1234};
  localparam logic [17:0] SEL [5] = '{18'h2ff20, 18'h2ffff, 18'h1ff00, 18'h1ff06, 18'h0ff07};
  dbc_link_if i_dbc_link_if ();
  dbc_host #(.HALF_CYC(12), .TURN_BITS(4)) i_dbc_host (.link(i_dbc_link_if), .*);
  dbc_device i_dbc_device (.link(i_dbc_link_if), .*);
  dbc_assertions i_dbc_assertions (.sclk(i_dbc_link_if.sclk), .h2d(i_dbc_link_if.h2d),
    .frame_n(i_dbc_link_if.frame_n), .*);
  // ----
  // Memory: fast rows answer at once, others one cycle late
  // ----
  assign mem_ready_i = mem_req_o & (fast | rdy_ff);
  assign mem_rdata_i = (mem_addr_o ^ 16'h5a5a) &
    (mem_word_o ? 16'hffff : (mem_addr_o[0] ? 16'h00ff : 16'hff00));
  always @(posedge mclk_i) begin
    rdy_ff <= mem_req_o & !mem_ready_i & !srst_i;
    fw_tx_load_i <= fw_cmd_valid_o;
    if (srst_i) begin
      n_acc <= 0;
      cap_c <= 8'h00;
    end else if (mem_req_o & mem_ready_i) begin
      {cap, cap_a, cap_d} <= {mem_we_o, mem_word_o, mem_bdmap_o, mem_addr_o, mem_wdata_o};
      n_acc <= n_acc + 1;
    end
    if (fw_cmd_valid_o) cap_c <= fw_code_o;
    if (fw_word_valid_o) cap_w <= fw_word_o;
  end
  // ----
  // Tasks and sequence
  // ----
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [15:0] g, input logic [15:0] x);
    num_checks++;
    if (g !== x) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk
  task automatic av(input logic w, input logic [4:0] ad, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge mclk_i);
    {avs_read_i, avs_write_i, avs_address_i, avs_writedata_i} <= {!w, w, ad, wd};
    do begin
      @(posedge mclk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 64);
    if (avs_waitrequest_o !== 1'b0) begin
      n_mismatch++;
      print_verdict();
    end else begin
      rdat = avs_readdata_o;
      {avs_read_i, avs_write_i} <= 2'b00;
    end
  endtask : av
  task automatic cmd(input logic [7:0] cc, input logic [3:0] fg, input logic [15:0] ca,
                     input logic [15:0] cd);
    int n;
    n = 0;
    av(1'b1, REG_ADDR, {16'h0, ca});
    av(1'b1, REG_WDATA, {16'h0, cd});
    av(1'b1, REG_CTRL, {20'h0, fg, cc});
    do begin
      av(1'b0, REG_STAT, 32'h0);
      n++;
    end while (rdat[STAT_BUSY] !== 1'b0 && n < 2000);
    if (rdat[STAT_BUSY] !== 1'b0) begin n_mismatch++; print_verdict(); end
  endtask : cmd
  task automatic rst();
    @(posedge mclk_i) srst_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    srst_i <= 1'b0;
    repeat (6) @(negedge mclk_i);
  endtask : rst
  task automatic ldp(input logic [15:0] x);
    @(posedge mclk_i) {ld_wr_i, shadow_prog_req_i} <= 2'b11;
    @(posedge mclk_i) {ld_wr_i, shadow_prog_req_i} <= 2'b00;
    @(negedge mclk_i) chk(16'({lockout_disable_bit_o, shadow_prog_o}), x);
  endtask : ldp
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  initial begin
    {srst_i, special_mode_pin_n_i, shadow_bit_i} = 3'b111;
    {ld_wr_i, ld_wdata_i, shadow_prog_req_i, fw_exit_i} = '0;
    {avs_read_i, avs_write_i, fast} = '0;
    {avs_address_i, avs_writedata_i, cpu_addr_i, fw_tx_data_i} = '0;
    {n_mismatch, num_checks} = '0;
    rst();
    chk(16'(lockout_disable_bit_o), 16'h1);
    foreach (ROWS[i]) begin
      {c, a, d} = ROWS[i];
      fast <= i[0];
      e = (a ^ 16'h5a5a) & (c[3] ? 16'hffff : (a[0] ? 16'h00ff : 16'hff00));
      cmd(c, 4'h0, a, d);
      chk(16'(cap), 16'({!c[5], c[3], c[2]}));
      chk(cap_a, a);
      chk(16'(n_acc), 16'(i + 1));
      if (c[5]) begin
        av(1'b0, REG_RDATA, 32'h0);
        chk(rdat[15:0], e);
      end else chk(cap_d, d);
    end
    // Odd word address must not reach memory
    cmd(8'he8, 4'h0, 16'h0123, 16'h0);
    chk(rdat[15:0], 16'h0002);
    chk(16'(n_acc), 16'h8);
    av(1'b1, REG_STAT, 32'h2);
    cmd(8'h44, {GAP_FW_WR, FMT_WR}, 16'h0, 16'h1111);
    chk(16'(cap_c), 16'h0);
    cmd(CMD_BACKGROUND, 4'h0, 16'h0, 16'h0);
    chk(16'(background_debug_mode_o), 16'h1);
    foreach (SEL[i]) begin
      @(posedge mclk_i) cpu_addr_i <= SEL[i][15:0];
      repeat (2) @(negedge mclk_i);
      chk(16'({rom_sel_o, dreg_sel_o}), 16'(SEL[i][17:16]));
    end
    cmd(8'h44, {GAP_FW_WR, FMT_WR}, 16'h0, 16'hc3a5);
    chk(16'(cap_c), 16'h44);
    chk(cap_w, 16'hc3a5);
    @(posedge mclk_i) fw_tx_data_i <= 16'h9c3e;
    cmd(8'h64, {GAP_STEP, FMT_RD}, 16'h0, 16'h0);
    chk(16'(cap_c), 16'h64);
    av(1'b0, REG_RDATA, 32'h0);
    chk(rdat[15:0], 16'h9c3e);
    @(posedge mclk_i) fw_exit_i <= 1'b1;
    @(posedge mclk_i) fw_exit_i <= 1'b0;
    repeat (3) @(negedge mclk_i);
    chk(16'(background_debug_mode_o), 16'h0);
    ldp(16'h2);
    @(posedge mclk_i) special_mode_pin_n_i <= 1'b0;
    repeat (5) @(posedge mclk_i);
    ldp(16'h1);
    cmd(CMD_BACKGROUND, 4'h0, 16'h0, 16'h0);
    chk(16'(background_debug_mode_o), 16'h0);
    cmd(8'he4, 4'h0, 16'hff02, 16'h0);
    chk(16'(cap[0]), 16'h0);
    @(posedge mclk_i) {special_mode_pin_n_i, shadow_bit_i} <= 2'b10;
    rst();
    chk(16'(lockout_disable_bit_o), 16'h0);
    print_verdict();
  end
endmodule : testbench
